// ### inc/pdsa_map.svh
`ifndef PDSA_MAP_SVH
`define PDSA_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define PDSA_OFF_PAGE   8'h00
`define PDSA_OFF_SP     8'h04
`define PDSA_OFF_STAT   8'h08

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define PDSA_STAT_TRAP  0
`define PDSA_STAT_BUSY  1
`define PDSA_STAT_PROG  2

// ----------------------------------------------------------------
// reset values and page boundaries
// ----------------------------------------------------------------
`define PDSA_PAGE_RST   10'h001
`define PDSA_PAGE_ZERO  10'h000
`define PDSA_PAGE_PS    10'h200
`define PDSA_PAGE_MAX   10'h3FF
`define PDSA_SP_RST     16'h1000
`define PDSA_SP_STEP    16'h0002

`endif

// ### inc/pdsa_pkg.sv
package pdsa_pkg;

  // ----------------------------------------------------------------
  // modes, stack operations and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PDSA_AM_PLAIN   = 3'h0,
    PDSA_AM_PREPOST = 3'h1,
    PDSA_AM_REGOFF  = 3'h2,
    PDSA_AM_MODULO  = 3'h3,
    PDSA_AM_BITREV  = 3'h4
  } pdsa_mode_t;

  typedef enum logic [2:0] {
    PDSA_OP_NONE = 3'h0,
    PDSA_OP_PUSH = 3'h1,
    PDSA_OP_POP  = 3'h2,
    PDSA_OP_CALL = 3'h3,
    PDSA_OP_EXC  = 3'h4
  } pdsa_stkop_t;

  typedef enum logic [1:0] {
    PDSA_ST_IDLE  = 2'b01,
    PDSA_ST_UPPER = 2'b10
  } pdsa_state_t;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0]  page;
    logic [15:0] sp;
    pdsa_state_t fsm;
    logic [15:0] hi_word;
    logic        acc_valid;
    logic [23:0] acc_addr;
    logic        acc_prog;
    logic [15:0] ea_next;
    logic        trap;
    logic        trap_flag;
    logic        mem_we;
    logic        mem_re;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic        busy;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pdsa_state_s_t;

endpackage : pdsa_pkg

// ### rtl/pdsa_agu.sv
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "pdsa_map.svh"

// Function
// - EA bit 15 set gives 24-bit address {page[8:0], EA[14:0]} for any nonzero page.
// - pages 0x200 and above map to program space, read only.
// - page carry only for paged start address with pre/post modified indirect.
// - overflow increments page and keeps EA bit 15 set.
// - underflow decrements page and keeps EA bit 15 set.
// - offset, modulo, bit-reversed modes keep page, set EA bit 15, wrap.
// - overflow at 0x3FF, underflow at 0x001/0x200 keep page, clear bit 15.
// - paged access with page zero raises address error trap, no access.
// - reset loads page register with 0x001.
// - writing zero to the page register is ignored.
// - addresses with EA bit 15 clear are always direct.
// - other pages reachable only through upper half with page register.
// - stack pointer moves on exceptions, calls, returns; stays read/writable.
// - stack pointer bit 0 is always zero.
// - reset loads stack pointer with 0x1000.
// - stack grows upward; push writes then increments, pop decrements then reads.
// - pc push stores bits 15:0 first, then bits 22:16 in next word.
// - on a call the upper stacked word has a zero top byte.
// - on exception the upper word carries the status low byte.
// - stack and active frame pointer are never paged, stay 16-bit.
module pdsa_agu (
  input  wire logic               sys_clk_i,       // core clock
  input  wire logic               nrst_i,          // async reset, low
  // apb slave
  input  wire logic               psel_i,          // apb select
  input  wire logic               penable_i,       // apb access phase
  input  wire logic               pwrite_i,        // apb write
  input  wire logic [7:0]         paddr_i,         // apb byte address
  input  wire logic [31:0]        pwdata_i,        // apb write data
  output logic                    pready_o,        // apb ready
  output logic                    pslverr_o,       // apb error
  output logic [31:0]             prdata_o,        // apb read data
  // effective address request
  input  wire logic               ea_req_i,        // address request
  input  wire logic               ea_wr_i,         // request is a write
  input  wire pdsa_pkg::pdsa_mode_t ea_mode_i,     // addressing mode
  input  wire logic [15:0]        ea_base_i,       // unmodified address
  input  wire logic [15:0]        ea_ofs_i,        // signed modification
  input  wire logic               ea_sp_i,         // base is stack pointer
  input  wire logic               ea_fp_i,         // base is frame pointer
  input  wire logic               sfa_i,           // stack frame active
  output logic                    acc_valid_o,     // access issued
  output logic [23:0]             acc_addr_o,      // access address
  output logic                    acc_prog_o,      // access to program space
  output logic [15:0]             ea_next_o,       // updated pointer value
  output logic                    trap_o,          // address error trap
  output logic [9:0]              page_o,          // read page register
  // stack
  input  wire pdsa_pkg::pdsa_stkop_t stk_op_i,     // stack operation
  input  wire logic [15:0]        stk_data_i,      // push data
  input  wire logic [22:0]        pc_i,            // program counter
  input  wire logic [7:0]         srl_i,           // status low byte
  input  wire logic               sp_wr_i,         // cpu writes sp
  input  wire logic [15:0]        sp_wdata_i,      // cpu sp value
  output logic [15:0]             sp_o,            // stack pointer
  output logic                    stk_busy_o,      // upper word pending
  output logic                    mem_we_o,        // data memory write
  output logic                    mem_re_o,        // data memory read
  output logic [15:0]             mem_addr_o,      // data memory address
  output logic [15:0]             mem_wdata_o      // data memory data
);
  import pdsa_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pdsa_state_s_t s;
  pdsa_state_s_t next_s;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] form_addr(input logic [9:0] pg,
                                             input logic [15:0] ea,
                                             input logic nopage);
    if (nopage || !ea[15]) begin
      form_addr = {8'h00, ea};
    end else begin
      form_addr = {pg[8:0], ea[14:0]};
    end
  endfunction : form_addr

  // stack pointer moves by one word either way; used by push, pop and frames
  function automatic logic [15:0] sp_up(input logic [15:0] sp);
    sp_up = sp + `PDSA_SP_STEP;
  endfunction : sp_up

  function automatic logic [15:0] sp_down(input logic [15:0] sp);
    sp_down = sp - `PDSA_SP_STEP;
  endfunction : sp_down

  logic [15:0] ea_res;
  logic        win;
  logic        ov;
  logic        un;
  logic        nopage;
  logic        apb_wr;
  logic        apb_setup;

  assign ea_res    = ea_base_i + ea_ofs_i;
  assign nopage    = ea_sp_i | (ea_fp_i & sfa_i);
  assign win       = ea_base_i[15] & ~nopage;
  assign ov        = win & ~ea_ofs_i[15] & ~ea_res[15];
  assign un        = win & ea_ofs_i[15] & ~ea_res[15];
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr    = psel_i & penable_i & pwrite_i & s.pready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [9:0]  pg;
    logic [15:0] e;
    pg     = s.page;
    e      = ea_res;
    next_s = s;
    next_s.acc_valid = 1'b0;
    next_s.trap      = 1'b0;
    next_s.mem_we    = 1'b0;
    next_s.mem_re    = 1'b0;
    next_s.pready    = 1'b0;
    next_s.pslverr   = 1'b0;

    // paged address generation
    if (ea_req_i) begin
      if (ov || un) begin
        if (ea_mode_i == PDSA_AM_PREPOST) begin
          if (ov && s.page == `PDSA_PAGE_MAX) begin
            e[15] = 1'b0;
          end else if (un && (s.page == `PDSA_PAGE_RST || s.page == `PDSA_PAGE_PS)) begin
            e[15] = 1'b0;
          end else if (ov) begin
            pg    = s.page + 10'h001;
            e[15] = 1'b1;
          end else begin
            pg    = s.page - 10'h001;
            e[15] = 1'b1;
          end
        end else if (ea_mode_i != PDSA_AM_PLAIN) begin
          e[15] = 1'b1;
        end
      end
      next_s.page    = pg;
      next_s.ea_next = e;
      // page zero cannot be reached through the upper half, and program
      // space is read only, so both abort the access with a trap
      if (!nopage && e[15] && (pg == `PDSA_PAGE_ZERO || (pg[9] && ea_wr_i))) begin
        next_s.trap      = 1'b1;
        next_s.trap_flag = 1'b1;
      end else begin
        next_s.acc_valid = 1'b1;
        next_s.acc_addr  = form_addr(pg, e, nopage);
        next_s.acc_prog  = !nopage && e[15] && pg[9];
      end
    end else if (apb_wr && paddr_i == `PDSA_OFF_PAGE) begin
      if (pwdata_i[9:0] != `PDSA_PAGE_ZERO) begin
        next_s.page = pwdata_i[9:0];
      end
    end

    // status flag clear, trap set wins
    if (apb_wr && paddr_i == `PDSA_OFF_STAT && pwdata_i[`PDSA_STAT_TRAP] && !next_s.trap) begin
      next_s.trap_flag = 1'b0;
    end

    // stack engine
    unique case (s.fsm)
      PDSA_ST_IDLE: begin
        unique case (stk_op_i)
          PDSA_OP_PUSH: begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = s.sp;
            next_s.mem_wdata = stk_data_i;
            next_s.sp        = sp_up(s.sp);
          end
          PDSA_OP_POP: begin
            next_s.mem_re   = 1'b1;
            next_s.mem_addr = sp_down(s.sp);
            next_s.sp       = sp_down(s.sp);
          end
          PDSA_OP_CALL, PDSA_OP_EXC: begin
            next_s.mem_we    = 1'b1;
            next_s.mem_addr  = s.sp;
            next_s.mem_wdata = pc_i[15:0];
            next_s.sp        = sp_up(s.sp);
            next_s.fsm       = PDSA_ST_UPPER;
            if (stk_op_i == PDSA_OP_CALL) begin
              next_s.hi_word = {8'h00, 1'b0, pc_i[22:16]};
            end else begin
              next_s.hi_word = {srl_i, 1'b0, pc_i[22:16]};
            end
          end
          default: begin
            if (sp_wr_i) begin
              next_s.sp = {sp_wdata_i[15:1], 1'b0};
            end else if (apb_wr && paddr_i == `PDSA_OFF_SP) begin
              next_s.sp = {pwdata_i[15:1], 1'b0};
            end
          end
        endcase
      end
      PDSA_ST_UPPER: begin
        next_s.mem_we    = 1'b1;
        next_s.mem_addr  = s.sp;
        next_s.mem_wdata = s.hi_word;
        next_s.sp        = sp_up(s.sp);
        next_s.fsm       = PDSA_ST_IDLE;
      end
      default: begin
        next_s.fsm = PDSA_ST_IDLE;
      end
    endcase
    next_s.busy = (next_s.fsm == PDSA_ST_UPPER);

    // apb: data and ready are prepared in the setup cycle so that
    // every bus output comes from a flop; one access cycle, no waits
    if (apb_setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0000_0000;
      unique case (paddr_i)
        `PDSA_OFF_PAGE: next_s.prdata = {22'h00_0000, s.page};
        `PDSA_OFF_SP:   next_s.prdata = {16'h0000, s.sp};
        `PDSA_OFF_STAT: begin
          next_s.prdata[`PDSA_STAT_TRAP] = s.trap_flag;
          next_s.prdata[`PDSA_STAT_BUSY] = s.busy;
          next_s.prdata[`PDSA_STAT_PROG] = s.acc_prog;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s           <= '0;
      s.page      <= `PDSA_PAGE_RST;
      s.sp        <= `PDSA_SP_RST;
      s.fsm       <= PDSA_ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready_o    = s.pready;
  assign pslverr_o   = s.pslverr;
  assign prdata_o    = s.prdata;
  assign acc_valid_o = s.acc_valid;
  assign acc_addr_o  = s.acc_addr;
  assign acc_prog_o  = s.acc_prog;
  assign ea_next_o   = s.ea_next;
  assign trap_o      = s.trap;
  assign page_o      = s.page;
  assign sp_o        = s.sp;
  assign stk_busy_o  = s.busy;
  assign mem_we_o    = s.mem_we;
  assign mem_re_o    = s.mem_re;
  assign mem_addr_o  = s.mem_addr;
  assign mem_wdata_o = s.mem_wdata;

endmodule : pdsa_agu

// ### tb/pdsa_monitor.sv
`timescale 1ns/1ps
module pdsa_monitor
  import pdsa_pkg::*;
(
  input wire logic                  sys_clk_i,   // clock
  input wire logic                  nrst_i,      // reset
  input wire logic                  ea_req_i,    // request
  input wire logic                  ea_wr_i,     // write
  input wire pdsa_pkg::pdsa_mode_t  ea_mode_i,   // mode
  input wire logic [15:0]           ea_base_i,   // base
  input wire logic [15:0]           ea_ofs_i,    // offset
  input wire logic                  ea_sp_i,     // sp base
  input wire logic                  ea_fp_i,     // fp base
  input wire logic                  acc_valid_o, // access
  input wire logic [23:0]           acc_addr_o,  // address
  input wire logic                  acc_prog_o,  // program space
  input wire logic                  trap_o,      // trap
  input wire logic [9:0]            page_o,      // page
  input wire pdsa_pkg::pdsa_stkop_t stk_op_i,    // stack op
  input wire logic                  stk_busy_o,  // busy
  input wire logic [15:0]           sp_o,        // sp
  input wire logic                  mem_we_o,    // write strobe
  input wire logic [15:0]           mem_addr_o,  // address
  input wire logic [15:0]           mem_wdata_o  // data
);
  logic plain;
  // unmodified requests only, so the page never moves under these checks
  assign plain = ea_req_i && ea_mode_i == PDSA_AM_PLAIN && ea_ofs_i == 16'h0000 && !ea_sp_i && !ea_fp_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  sp_align_a: assert property (sp_o[0] == 1'b0) else $error("stack pointer odd");
  page_nonzero_a: assert property (page_o != 10'h000) else $error("page cleared");
  rst_value_a: assert property (!$past(nrst_i) |-> page_o == 10'h001 && sp_o == 16'h1000)
    else $error("bad reset value");
  direct_addr_a: assert property (plain && !ea_base_i[15] |=> acc_valid_o && acc_addr_o == {8'h00, $past(ea_base_i)})
    else $error("direct access paged");
  psv_read_a: assert property (plain && ea_base_i[15] && page_o[9] && !ea_wr_i |=> acc_valid_o && acc_prog_o
    && acc_addr_o == {$past(page_o[8:0]), $past(ea_base_i[14:0])}) else $error("bad window address");
  prog_write_a: assert property (plain && ea_base_i[15] && page_o[9] && ea_wr_i |=> trap_o && !acc_valid_o)
    else $error("program write not refused");
  sp_flat_a: assert property (ea_req_i && ea_sp_i && ea_mode_i == PDSA_AM_PLAIN
    |=> acc_addr_o[23:16] == 8'h00 && !acc_prog_o) else $error("stack access paged");
  push_order_a: assert property (stk_op_i == PDSA_OP_PUSH && !stk_busy_o |=> mem_we_o
    && mem_addr_o == $past(sp_o) && sp_o == $past(sp_o) + 16'h0002) else $error("bad push");
  call_frame_a: assert property (stk_op_i == PDSA_OP_CALL && !stk_busy_o |=> stk_busy_o ##1 (mem_we_o
    && !stk_busy_o && mem_wdata_o[15:7] == 9'h000 && mem_addr_o == $past(sp_o, 2) + 16'h0002))
    else $error("bad call frame");
endmodule : pdsa_monitor

bind pdsa_agu pdsa_monitor u_mon (.*);

// ### tb/pdsa_mem_model.sv
`timescale 1ns/1ps
module pdsa_mem_model (
  input wire logic        clk_i,   // core clock
  input wire logic        we_i,    // write strobe
  input wire logic [15:0] addr_i,  // byte address
  input wire logic [15:0] wdata_i  // write data
);
  // word store indexed by word address; an unwritten word reads as unknown
  logic [15:0] ram [0:32767];
  always @(posedge clk_i) begin
    if (we_i) begin
      ram[addr_i[15:1]] <= wdata_i;
    end
  end
endmodule : pdsa_mem_model

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "pdsa_map.svh"
module testbench;
  import pdsa_pkg::*;
  logic        sys_clk_i = 1'b0, nrst_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic        ea_req_i = 1'b0, ea_wr_i = 1'b0, ea_sp_i = 1'b0, ea_fp_i = 1'b0, sfa_i = 1'b0, sp_wr_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00, srl_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, r;
  logic [15:0] ea_base_i = 16'h0, ea_ofs_i = 16'h0, stk_data_i = 16'h0, sp_wdata_i = 16'h0, b;
  logic [22:0] pc_i = 23'h0;
  logic        pready_o, pslverr_o, acc_valid_o, acc_prog_o, trap_o, stk_busy_o, mem_we_o, mem_re_o, err;
  logic [23:0] acc_addr_o;
  logic [15:0] ea_next_o, sp_o, mem_addr_o, mem_wdata_o;
  logic [9:0]  page_o;
  pdsa_mode_t  ea_mode_i = PDSA_AM_PLAIN, m;
  pdsa_stkop_t stk_op_i = PDSA_OP_NONE;
  int          mismatches = 0, n_checks = 0;
  integer      seed = 32'hD60B;

  pdsa_agu uut (.*);
  pdsa_mem_model u_mem (.clk_i(sys_clk_i), .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o));

  always #5 sys_clk_i = ~sys_clk_i;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  function automatic void predict(input pdsa_mode_t md, input logic [9:0] pg, input logic [15:0] bs, o,
                                  output logic [9:0] np, output logic [15:0] ne);
    np = pg;
    ne = bs + o;
    if (bs[15] && !ne[15] && md != PDSA_AM_PLAIN) begin
      ne[15] = 1'b1;
      if (md == PDSA_AM_PREPOST) begin
        if (o[15] ? (pg == 10'h001 || pg == 10'h200) : pg == 10'h3FF) begin
          ne[15] = 1'b0;
        end else begin
          np = o[15] ? pg - 10'h001 : pg + 10'h001;
        end
      end
    end
  endfunction : predict

  task ea(input pdsa_mode_t md, input logic [9:0] pg, input logic [15:0] bs, o, input logic w, input logic [2:0] f);
    logic [9:0]  np;
    logic [15:0] ne;
    logic        pgd;
    apb(1'b1, `PDSA_OFF_PAGE, {22'h0, pg});
    @(posedge sys_clk_i);
    ea_req_i <= 1'b1;
    ea_mode_i <= md;
    ea_base_i <= bs;
    ea_ofs_i <= o;
    ea_wr_i <= w;
    {ea_sp_i, ea_fp_i, sfa_i} <= f;
    @(posedge sys_clk_i);
    ea_req_i <= 1'b0;
    #1;
    predict(md, pg, bs, o, np, ne);
    pgd = ne[15] && !(f[2] || (f[1] && f[0]));
    chk(page_o, np);
    chk(ea_next_o, ne);
    chk(trap_o, pgd && w && np[9]);
    chk(acc_valid_o, !(pgd && w && np[9]));
    if (acc_valid_o === 1'b1) begin
      chk(acc_addr_o, pgd ? {np[8:0], ne[14:0]} : {8'h00, ne});
      chk(acc_prog_o, pgd && np[9]);
    end
  endtask : ea

  task stk(input pdsa_stkop_t op);
    logic [15:0] s0;
    s0 = sp_o;
    r = $random(seed);
    @(posedge sys_clk_i);
    stk_op_i <= op;
    stk_data_i <= r[15:0];
    pc_i <= r[22:0];
    srl_i <= r[31:24];
    @(posedge sys_clk_i);
    stk_op_i <= PDSA_OP_NONE;
    #1;
    chk(mem_we_o, op != PDSA_OP_POP);
    chk(mem_re_o, op == PDSA_OP_POP);
    chk(stk_busy_o, op >= PDSA_OP_CALL);
    if (op >= PDSA_OP_CALL) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    #1;
    if (op == PDSA_OP_POP) chk(mem_addr_o, s0 - 16'h0002);
    if (op != PDSA_OP_POP) chk(u_mem.ram[s0[15:1]], r[15:0]);
    if (op >= PDSA_OP_CALL) chk(u_mem.ram[s0[15:1] + 15'h0001], {op == PDSA_OP_EXC ? r[31:24] : 8'h00, 1'b0, r[22:16]});
    chk(sp_o, op == PDSA_OP_POP ? s0 - 16'h0002 : s0 + (op == PDSA_OP_PUSH ? 16'h0002 : 16'h0004));
  endtask : stk

  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    apb(1'b0, `PDSA_OFF_PAGE, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, `PDSA_OFF_SP, 32'h0);
    chk(rd, 32'h0000_1000);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, `PDSA_OFF_SP, 32'h0000_3003);
    apb(1'b0, `PDSA_OFF_SP, 32'h0);
    chk(rd, 32'h0000_3002);
    ea(PDSA_AM_PLAIN, 10'h150, 16'h1234, 16'h0, 1'b0, 3'b000);
    apb(1'b1, `PDSA_OFF_PAGE, 32'h0);
    apb(1'b0, `PDSA_OFF_PAGE, 32'h0);
    chk(rd, 32'h0000_0150);
    // page boundary corners: overflow at 0x3FF, underflow at 0x001 and 0x200, plus ordinary crossings
    ea(PDSA_AM_PREPOST, 10'h2FF, 16'hFFFE, 16'h0002, 1'b0, 3'b000);
    ea(PDSA_AM_PREPOST, 10'h3FF, 16'hFFFE, 16'h0002, 1'b0, 3'b000);
    ea(PDSA_AM_PREPOST, 10'h001, 16'h8000, 16'hFFFE, 1'b0, 3'b000);
    ea(PDSA_AM_PREPOST, 10'h200, 16'h8000, 16'hFFFE, 1'b0, 3'b000);
    ea(PDSA_AM_PREPOST, 10'h300, 16'h8000, 16'hFFFE, 1'b0, 3'b000);
    ea(PDSA_AM_PREPOST, 10'h150, 16'h7FFE, 16'h0002, 1'b0, 3'b000);
    for (int i = 2; i < 5; i++) ea(pdsa_mode_t'(3'(i)), 10'h150, 16'hFFFE, 16'h0004, 1'b0, 3'b000);
    ea(PDSA_AM_PLAIN, 10'h250, 16'h9000, 16'h0, 1'b0, 3'b100);
    ea(PDSA_AM_PLAIN, 10'h250, 16'h9000, 16'h0, 1'b0, 3'b011);
    ea(PDSA_AM_PLAIN, 10'h250, 16'h9000, 16'h0, 1'b1, 3'b010);
    apb(1'b0, `PDSA_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b1, `PDSA_OFF_STAT, 32'h0000_0001);
    apb(1'b0, `PDSA_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_0000);
    repeat (60) begin
      r = $random(seed);
      m = r[2:0] > 3'h4 ? PDSA_AM_PREPOST : pdsa_mode_t'(r[2:0]);
      b = r[31:16];
      b[13:5] = {9{b[14]}};
      ea(m, r[18:9] == 10'h000 ? 10'h001 : r[18:9], b, m == PDSA_AM_PLAIN ? 16'h0 : {{10{r[8]}}, r[8:3]},
         m == PDSA_AM_PLAIN && r[19], m == PDSA_AM_PLAIN ? r[22:20] : 3'b000);
    end
    @(posedge sys_clk_i);
    sp_wr_i <= 1'b1;
    sp_wdata_i <= 16'h2001;
    @(posedge sys_clk_i);
    sp_wr_i <= 1'b0;
    #1;
    chk(sp_o, 16'h2000);
    repeat (24) begin
      r = $random(seed);
      stk(pdsa_stkop_t'({1'b0, r[1:0]} + 3'h1));
    end
    // second reset in mid-run: every reset restores page and stack pointer
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk(page_o, 32'h0000_0001);
    chk(sp_o, 32'h0000_1000);
    wrap_up;
  end

  initial begin
    #100000;
    mismatches++;
    wrap_up;
  end
endmodule : testbench
